// *** logic/spdif_sup_cfg.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the lock
 * and clock supervisor.
 * Assumes a 50 MHz system clock standing in for the crystal timebase.
 */
`ifndef SPDIF_SUP_CFG_SVH
`define SPDIF_SUP_CFG_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define REG_SYS_IDX 4'h0
`define REG_CLK_IDX 4'h1
`define REG_DATA_IDX 4'h2
`define REG_STAT_IDX 4'h3
`define REG_STAT2_IDX 4'h9

// ==========================================================
// Field positions
`define SYS_REJECT_BIT 3
`define SYS_LOCK_WAIT_BIT 4
`define SYS_UNLOCK_MUTE_BIT 5
`define SYS_DIR_SEL_BIT 6
`define CLK_TYPE_BIT 0
`define CLK_VAR_LSB 1
`define CLK_FIX_LSB 3
`define DATA_RX_SRC_BIT 1
`define STAT_ERR_BIT 4

// ==========================================================
// Reset values
`define SYS_RESET 8'h00
`define CLK_RESET 8'h00
`define DATA_RESET 8'h00

// ==========================================================
// Timing
`define CLK_FREQ_MHZ 50
`define CLK_FREQ_HZ 50000000
`define SWITCH_DELAY_US 2700
`define SWITCH_CYCLES (`SWITCH_DELAY_US * `CLK_FREQ_MHZ)
`define TICK_FREQ_HZ 48000
`define TICK_DIV_CYCLES (`CLK_FREQ_HZ / `TICK_FREQ_HZ)
`define MUTE_TICKS_SHORT 15'h0100
`define MUTE_TICKS_LONG 15'h4000
`define LOCK_WAIT_SHORT 3'h3
`define LOCK_WAIT_LONG 3'h6

`endif

// *** logic/spdif_sup_pkg.sv ***
/*
 * Types shared by the lock and clock supervisor.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package spdif_sup_pkg;

    // ==========================================================
    // Lock judging states, Gray along the lock-in path
    typedef enum logic [2:0] {
        ST_UNLOCK = 3'h0,
        ST_SYNC = 3'h1,
        ST_WAIT_B = 3'h3,
        ST_COUNT = 3'h2,
        ST_LOCKED = 3'h6
    } lock_state_t;

    // Master clock source and multiple
    typedef enum logic [1:0] {
        MULT_XTAL = 2'h0,
        MULT_128 = 2'h1,
        MULT_256 = 2'h2,
        MULT_512 = 2'h3
    } mult_t;

    // Input rate class: 32-48k, 64-96k, 128-192k, other
    typedef enum logic [1:0] {
        FS_BASE = 2'h0,
        FS_DOUBLE = 2'h1,
        FS_QUAD = 2'h2,
        FS_OTHER = 2'h3
    } fs_class_t;

    // One-cycle preamble detector events
    typedef struct packed {
        logic pre_m;
        logic pre_w;
        logic pre_b;
        logic pre_bad;
    } preamble_t;

    // System control bits
    typedef struct packed {
        logic receive_reject_mode;
        logic lock_wait_count_sel;
        logic unlock_mute_sel;
        logic multi_pin_dir_sel;
    } sys_ctrl_t;

    // Clock multiple control bits
    typedef struct packed {
        logic clock_multiple_type;
        logic [1:0] variable_multiple_sel;
        logic [1:0] fixed_multiple_sel;
    } clk_ctrl_t;

endpackage

// *** logic/tick_divider.sv ***
/*
 * Divides the system clock down to the 48 kHz unlock-mute timebase.
 * Assumes one synchronous clock and an active-high asynchronous reset.
 */
`timescale 1ns/1ps

module tick_divider #(
    parameter int DIV = 1041
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);

    // ==========================================================
    // Elaboration check
    generate
        if (DIV < 2 || DIV > 65535)
        begin : g_bad_div
            $error("tick_divider: DIV out of range");
        end
    endgenerate

    logic [15:0] cnt_q;

    // Free-running divide counter
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 16'h0000;
        end
        else if (cnt_q == 16'(DIV - 1))
        begin
            cnt_q <= 16'h0000;
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign tick = (cnt_q == 16'(DIV - 1));

endmodule

// *** logic/spdif_lock_supervisor.sv ***
/*
 * Lock judging, oscillator control, output clock switching and output
 * muting of a digital audio receiver, with an APB register slave.
 * Assumes preamble detector events and rate class arrive synchronous
 * to CLK, and that the clock multiplexers sit outside this block.
 */
// Design decisions made here: the register addresses and the APB interface to the registers.
// Notes on behaviour
// - Oscillator amplifier stops exactly when the lock error output falls.
// - Oscillator amplifier restarts exactly when the lock error output rises.
// - Output clock source follows PLL lock state about 2.7 ms later.
// - A second PLL change inside the delay cancels the pending switch.
// - Reject mode forces unlock regardless of input; crystal clock runs outputs.
// - Reject mode: error high, crystal master clock, aux data passed through.
// - Lock error output high while unlocked, low while locked with no clock switch pending.
// - Lock judged after sync, an M then W cycle, then a B preamble.
// - After judging, error stays high until B count reaches the wait setting.
// - Default wait is three B preambles.
// - Wait setting chooses three or six B preambles.
// - Bad preambles drop lock; no received audio until error releases.
// - After unlock, data muted for a wait, then aux data output.
// - Unlock mute counts 48 kHz ticks: 256 or 16384.
// - Reaching the locked state cancels unlock mute; during the lock wait the mute count keeps running.
// - Pin direction select: 0 drives emphasis out, 1 makes the pin an input; data register bit 1 picks it as stream.
// - Default multiples: 512fs base, 256fs double, 128fs quad rates.
// - Locked multiple comes from variable or fixed selection.
// - Multiple type bit clear selects variable, set selects fixed.
// - During a clock switch, error held high and data muted.
`timescale 1ns/1ps
`include "spdif_sup_cfg.svh"

module spdif_lock_supervisor #(
    parameter int SWITCH_CYCLES = `SWITCH_CYCLES,
    parameter int TICK_DIV = `TICK_DIV_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PLL_SYNC,
    input wire spdif_sup_pkg::preamble_t PREAMBLE,
    input wire spdif_sup_pkg::fs_class_t FS_CLASS,
    input wire logic RX_AUDIO_DATA,
    input wire logic AUX_SERIAL_DATA_IN,
    input wire logic EMPHASIS_FLAG,
    input wire logic RX_PIN_IN,
    input wire logic MULTI_PURPOSE_PIN_IN,
    output logic MULTI_PURPOSE_PIN_OUT,
    output logic MULTI_PURPOSE_PIN_OE,
    output logic SPDIF_STREAM_SEL,
    output logic LOCK_ERR,
    output logic OSC_AMP_EN,
    output logic CLK_SRC_PLL,
    output spdif_sup_pkg::mult_t MASTER_CLOCK_OUT_SEL,
    output logic SERIAL_DATA_OUT
);

    // ==========================================================
    // Elaboration check
    generate
        if (SWITCH_CYCLES < 2 || SWITCH_CYCLES > 1048575)
        begin : g_bad_switch
            $error("spdif_lock_supervisor: SWITCH_CYCLES out of range");
        end
    endgenerate

    // ==========================================================
    // Declarations
    spdif_sup_pkg::sys_ctrl_t sys_q;
    spdif_sup_pkg::clk_ctrl_t clk_cfg_q;
    spdif_sup_pkg::clk_ctrl_t clk_lat_q;
    logic rx_src_sel_q;
    spdif_sup_pkg::lock_state_t state_q;
    spdif_sup_pkg::lock_state_t state_d;
    logic m_seen_q;
    logic [2:0] b_cnt_q;
    logic [2:0] wait_target_q;
    logic pll_lock_q;
    logic pll_lock_d;
    logic [19:0] sw_cnt_q;
    logic sw_target_q;
    logic clk_src_q;
    logic sw_active;
    logic err_d;
    logic err_q;
    logic osc_q;
    logic [14:0] mute_cnt_q;
    logic mute_q;
    logic tick;
    logic data_q;
    logic abort;
    logic judged;
    logic wr_en;
    logic [3:0] reg_idx;
    logic mapped;
    logic [31:0] rd_mux;
    logic [31:0] rdata_q;
    spdif_sup_pkg::mult_t mult_sel;

    // ==========================================================
    // 48 kHz timebase
    tick_divider #(
        .DIV(TICK_DIV)
    ) tick_divider_inst (
        .clk(CLK),
        .rst(RST),
        .tick(tick)
    );

    // ==========================================================
    // APB slave, zero wait states
    assign reg_idx = PADDR[5:2];
    assign mapped = (PADDR[7:6] == 2'h0) && (PADDR[1:0] == 2'h0) &&
        (reg_idx == `REG_SYS_IDX || reg_idx == `REG_CLK_IDX ||
         reg_idx == `REG_DATA_IDX || reg_idx == `REG_STAT_IDX ||
         reg_idx == `REG_STAT2_IDX);
    assign wr_en = PSEL && PENABLE && PWRITE && mapped;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA = rdata_q;

    // Control register writes
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            sys_q <= '0;
            clk_cfg_q <= '0;
            rx_src_sel_q <= 1'b0;
        end
        else if (wr_en)
        begin
            if (reg_idx == `REG_SYS_IDX)
            begin
                sys_q.receive_reject_mode <= PWDATA[`SYS_REJECT_BIT];
                sys_q.lock_wait_count_sel <= PWDATA[`SYS_LOCK_WAIT_BIT];
                sys_q.unlock_mute_sel <= PWDATA[`SYS_UNLOCK_MUTE_BIT];
                sys_q.multi_pin_dir_sel <= PWDATA[`SYS_DIR_SEL_BIT];
            end
            if (reg_idx == `REG_CLK_IDX)
            begin
                clk_cfg_q.clock_multiple_type <= PWDATA[`CLK_TYPE_BIT];
                clk_cfg_q.variable_multiple_sel <= PWDATA[`CLK_VAR_LSB +: 2];
                clk_cfg_q.fixed_multiple_sel <= PWDATA[`CLK_FIX_LSB +: 2];
            end
            if (reg_idx == `REG_DATA_IDX)
            begin
                rx_src_sel_q <= PWDATA[`DATA_RX_SRC_BIT];
            end
        end
    end

    // Read mux
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (reg_idx)
            `REG_SYS_IDX:
            begin
                rd_mux[`SYS_REJECT_BIT] = sys_q.receive_reject_mode;
                rd_mux[`SYS_LOCK_WAIT_BIT] = sys_q.lock_wait_count_sel;
                rd_mux[`SYS_UNLOCK_MUTE_BIT] = sys_q.unlock_mute_sel;
                rd_mux[`SYS_DIR_SEL_BIT] = sys_q.multi_pin_dir_sel;
            end
            `REG_CLK_IDX:
            begin
                rd_mux[`CLK_TYPE_BIT] = clk_cfg_q.clock_multiple_type;
                rd_mux[`CLK_VAR_LSB +: 2] = clk_cfg_q.variable_multiple_sel;
                rd_mux[`CLK_FIX_LSB +: 2] = clk_cfg_q.fixed_multiple_sel;
            end
            `REG_DATA_IDX: rd_mux[`DATA_RX_SRC_BIT] = rx_src_sel_q;
            `REG_STAT_IDX: rd_mux[`STAT_ERR_BIT] = err_q;
            `REG_STAT2_IDX: rd_mux[7:0] = {mute_q, sw_active, osc_q, clk_src_q, 1'b0, state_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup phase
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (PSEL && !PENABLE && !PWRITE)
        begin
            rdata_q <= mapped ? rd_mux : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Lock judging
    assign abort = !PLL_SYNC || PREAMBLE.pre_bad || sys_q.receive_reject_mode;
    assign judged = (state_q == spdif_sup_pkg::ST_WAIT_B) && PREAMBLE.pre_b && !abort;

    // Next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            spdif_sup_pkg::ST_UNLOCK:
                if (PLL_SYNC) state_d = spdif_sup_pkg::ST_SYNC;
            spdif_sup_pkg::ST_SYNC:
                if (m_seen_q && PREAMBLE.pre_w) state_d = spdif_sup_pkg::ST_WAIT_B;
            spdif_sup_pkg::ST_WAIT_B:
                if (PREAMBLE.pre_b) state_d = spdif_sup_pkg::ST_COUNT;
            spdif_sup_pkg::ST_COUNT:
                if (PREAMBLE.pre_b && (b_cnt_q + 3'h1 == wait_target_q))
                    state_d = spdif_sup_pkg::ST_LOCKED;
            spdif_sup_pkg::ST_LOCKED: state_d = spdif_sup_pkg::ST_LOCKED;
            default: state_d = spdif_sup_pkg::ST_UNLOCK;
        endcase
        if (abort)
        begin
            state_d = spdif_sup_pkg::ST_UNLOCK;
        end
    end

    // State register and M-preamble tracker
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state_q <= spdif_sup_pkg::ST_UNLOCK;
            m_seen_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            m_seen_q <= (state_d == spdif_sup_pkg::ST_SYNC) && (m_seen_q || PREAMBLE.pre_m);
        end
    end

    // B preamble count, target taken at judging
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            b_cnt_q <= 3'h0;
            wait_target_q <= `LOCK_WAIT_SHORT;
            clk_lat_q <= '0;
        end
        else if (judged)
        begin
            b_cnt_q <= 3'h0;
            wait_target_q <= sys_q.lock_wait_count_sel ? `LOCK_WAIT_LONG
                : `LOCK_WAIT_SHORT;
            clk_lat_q <= clk_cfg_q;
        end
        else if (state_q == spdif_sup_pkg::ST_COUNT && PREAMBLE.pre_b)
        begin
            b_cnt_q <= b_cnt_q + 3'h1;
        end
    end

    // ==========================================================
    // Clock source switching
    assign pll_lock_d = PLL_SYNC && !sys_q.receive_reject_mode;
    assign sw_active = (sw_cnt_q != 20'h0) && (sw_target_q != clk_src_q);

    // Delay counter restarted on each PLL change
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            pll_lock_q <= 1'b0;
            sw_cnt_q <= 20'h0;
            sw_target_q <= 1'b0;
            clk_src_q <= 1'b0;
        end
        else
        begin
            pll_lock_q <= pll_lock_d;
            if (pll_lock_d != pll_lock_q)
            begin
                sw_cnt_q <= 20'(SWITCH_CYCLES);
                sw_target_q <= pll_lock_d;
            end
            else if (sw_cnt_q != 20'h0)
            begin
                sw_cnt_q <= sw_cnt_q - 20'h1;
                if (sw_cnt_q == 20'h1)
                begin
                    clk_src_q <= sw_target_q;
                end
            end
        end
    end

    // ==========================================================
    // Lock error and oscillator
    assign err_d = (state_d != spdif_sup_pkg::ST_LOCKED) || sw_active
        || sys_q.receive_reject_mode;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            err_q <= 1'b1;
            osc_q <= 1'b1;
        end
        else
        begin
            err_q <= err_d;
            osc_q <= err_d;
        end
    end

    // ==========================================================
    // Unlock mute timing
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            mute_cnt_q <= 15'h0;
            mute_q <= 1'b0;
        end
        else if (state_d == spdif_sup_pkg::ST_LOCKED)
        begin
            mute_cnt_q <= 15'h0;
            mute_q <= 1'b0;
        end
        else if (state_q == spdif_sup_pkg::ST_LOCKED)
        begin
            mute_cnt_q <= sys_q.unlock_mute_sel ? `MUTE_TICKS_LONG
                : `MUTE_TICKS_SHORT;
            mute_q <= 1'b1;
        end
        else if (mute_q && tick)
        begin
            mute_cnt_q <= mute_cnt_q - 15'h1;
            mute_q <= (mute_cnt_q != 15'h1);
        end
    end

    // Serial data selection
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            data_q <= 1'b0;
        end
        else if (!err_d)
        begin
            data_q <= RX_AUDIO_DATA;
        end
        else if (mute_q || sw_active)
        begin
            data_q <= 1'b0;
        end
        else
        begin
            data_q <= AUX_SERIAL_DATA_IN;
        end
    end

    // ==========================================================
    // Master clock multiple
    always_comb
    begin
        mult_sel = spdif_sup_pkg::MULT_256;
        if (!clk_lat_q.clock_multiple_type)
        begin
            case (FS_CLASS)
                spdif_sup_pkg::FS_BASE: mult_sel = clk_lat_q.variable_multiple_sel[0]
                    ? spdif_sup_pkg::MULT_256 : spdif_sup_pkg::MULT_512;
                spdif_sup_pkg::FS_DOUBLE: mult_sel = clk_lat_q.variable_multiple_sel[1]
                    ? spdif_sup_pkg::MULT_512 : spdif_sup_pkg::MULT_256;
                spdif_sup_pkg::FS_QUAD: mult_sel = spdif_sup_pkg::MULT_128;
                default: mult_sel = spdif_sup_pkg::MULT_256;
            endcase
        end
        else
        begin
            case (clk_lat_q.fixed_multiple_sel)
                2'h1: mult_sel = spdif_sup_pkg::MULT_512;
                2'h2: mult_sel = spdif_sup_pkg::MULT_128;
                default: mult_sel = spdif_sup_pkg::MULT_256;
            endcase
        end
    end

    // Output clock select register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            MASTER_CLOCK_OUT_SEL <= spdif_sup_pkg::MULT_XTAL;
        end
        else if (!clk_src_q || sys_q.receive_reject_mode)
        begin
            MASTER_CLOCK_OUT_SEL <= spdif_sup_pkg::MULT_XTAL;
        end
        else
        begin
            MASTER_CLOCK_OUT_SEL <= mult_sel;
        end
    end

    // ==========================================================
    // Pin direction and stream source
    assign MULTI_PURPOSE_PIN_OE = !sys_q.multi_pin_dir_sel;
    assign MULTI_PURPOSE_PIN_OUT = EMPHASIS_FLAG && !sys_q.multi_pin_dir_sel;
    assign SPDIF_STREAM_SEL = rx_src_sel_q ? MULTI_PURPOSE_PIN_IN : RX_PIN_IN;
    assign LOCK_ERR = err_q;
    assign OSC_AMP_EN = osc_q;
    assign CLK_SRC_PLL = clk_src_q;
    assign SERIAL_DATA_OUT = data_q;

    // ==========================================================
    // Assertions
    a_reject_err: assert property (@(posedge CLK) disable iff (RST)
        sys_q.receive_reject_mode |=> LOCK_ERR)
        else $error("Error low in reject mode");
    a_osc_stop: assert property (@(posedge CLK) disable iff (RST)
        $fell(LOCK_ERR) |-> !OSC_AMP_EN && $past(OSC_AMP_EN))
        else $error("Oscillator not stopped with error fall");
    a_osc_start: assert property (@(posedge CLK) disable iff (RST)
        $rose(LOCK_ERR) |-> OSC_AMP_EN)
        else $error("Oscillator not restarted with error rise");
    a_switch_moment: assert property (@(posedge CLK) disable iff (RST)
        $changed(CLK_SRC_PLL) |-> $past(sw_cnt_q) == 20'h1 && CLK_SRC_PLL == $past(sw_target_q))
        else $error("Clock source changed at wrong moment");
    a_switch_restart: assert property (@(posedge CLK) disable iff (RST)
        (pll_lock_d != pll_lock_q) |=> sw_cnt_q == 20'(SWITCH_CYCLES))
        else $error("Switch delay not restarted");
    a_switch_err: assert property (@(posedge CLK) disable iff (RST)
        sw_active |=> LOCK_ERR)
        else $error("Error low during clock switch");
    a_lock_count: assert property (@(posedge CLK) disable iff (RST)
        $fell(LOCK_ERR) |-> b_cnt_q == wait_target_q
            || $past(state_q) == spdif_sup_pkg::ST_LOCKED)
        else $error("Error released before B count");
    a_mute_quiet: assert property (@(posedge CLK) disable iff (RST)
        (mute_q && err_d) |=> !SERIAL_DATA_OUT)
        else $error("Data not muted after unlock");
    a_relock_unmute: assert property (@(posedge CLK) disable iff (RST)
        state_q == spdif_sup_pkg::ST_LOCKED |-> !mute_q)
        else $error("Unlock mute active while locked");
    a_pin_dir: assert property (@(posedge CLK) disable iff (RST)
        sys_q.multi_pin_dir_sel |-> !MULTI_PURPOSE_PIN_OE)
        else $error("Pin driven while set as input");

    c_lock: cover property (@(posedge CLK) disable iff (RST) $fell(LOCK_ERR));
    c_unlock_mute: cover property (@(posedge CLK) disable iff (RST) $fell(mute_q));
    c_cancel: cover property (@(posedge CLK) disable iff (RST)
        (sw_cnt_q > 20'h1) && (pll_lock_d != pll_lock_q) && (pll_lock_d == clk_src_q));
    c_to_pll: cover property (@(posedge CLK) disable iff (RST) $rose(CLK_SRC_PLL));

endmodule

// *** verification/spdif_source.sv ***
/*
 * Stream source model: carrier sync level and preamble pulses.
 * Assumes the supervisor samples its outputs on the rising clock.
 */
`timescale 1ns/1ps
module spdif_source (
    input wire logic clk,
    input wire logic run,
    input wire logic bad,
    output logic sync,
    output spdif_sup_pkg::preamble_t pre
);
    logic [3:0] pos_q;
    // =============================
    // Subframe position, held at zero while stopped
    always_ff @(posedge clk)
    begin
        pos_q <= run ? pos_q + 4'h1 : 4'h0;
    end
    // Sync with the carrier; M before W, one B per block
    assign sync = run;
    assign pre = {run && pos_q[1:0] == 2'h1, run && pos_q[1:0] == 2'h3,
        run && pos_q == 4'h0, bad};
endmodule

// *** verification/spdif_lock_clock_supervisor_test.sv ***
/*
 * Self-checking bench for the lock and clock supervisor.
 * Assumes the package and the stream source model are compiled first.
 */
`timescale 1ns/1ps
module spdif_lock_clock_supervisor_test;
    localparam int SW = 50;
    localparam int TD = 4;
    logic CLK, RST, psel, pen, pwr, run, bad, rx, aux, emph, sync, pready, pslverr;
    logic oe, pin_out, lerr, osc, src, sdo, ssel;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    spdif_sup_pkg::preamble_t pre;
    spdif_sup_pkg::mult_t mult;
    spdif_sup_pkg::fs_class_t fs;
    int err_count, compares, n;
    // =============================
    // Design and stream source
    spdif_lock_supervisor #(.SWITCH_CYCLES(SW), .TICK_DIV(TD)) spdif_lock_supervisor_inst (
        .CLK(CLK), .RST(RST), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PLL_SYNC(sync), .PREAMBLE(pre), .FS_CLASS(fs),
        .RX_AUDIO_DATA(rx), .AUX_SERIAL_DATA_IN(aux), .EMPHASIS_FLAG(emph),
        .RX_PIN_IN(rx), .MULTI_PURPOSE_PIN_IN(emph), .MULTI_PURPOSE_PIN_OUT(pin_out),
        .MULTI_PURPOSE_PIN_OE(oe), .SPDIF_STREAM_SEL(ssel), .LOCK_ERR(lerr), .OSC_AMP_EN(osc),
        .CLK_SRC_PLL(src), .MASTER_CLOCK_OUT_SEL(mult), .SERIAL_DATA_OUT(sdo));
    spdif_source spdif_source_inst (.clk(CLK), .run(run), .bad(bad), .sync(sync), .pre(pre));
    // Clock
    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    // =============================
    // Verdict and comparison
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer, bounded wait on the ready signal
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
        int i;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge CLK);
        pen <= 1'b1;
        @(posedge CLK);
        for (i = 0; i < 20 && pready !== 1'b1; i++)
            @(posedge CLK);
        if (i == 20)
        begin
            err_count++;
            end_of_test;
        end
        q = prdata;
        chk("pslverr", {31'h0, er}, {31'h0, pslverr});
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge CLK);
    endtask
    // Bounded wait for a lock error level, cycles in n
    task automatic wait_err(input logic v);
        for (n = 0; n < 2000 && lerr !== v; n++)
            @(posedge CLK);
        if (n == 2000)
        begin
            err_count++;
            end_of_test;
        end
    endtask
    // =============================
    // Scenarios
    initial
    begin
        RST = 1'b1;
        {psel, pen, pwr, run, bad, rx, aux} = 7'h0;
        emph = 1'b1;
        fs = spdif_sup_pkg::FS_BASE;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_count = 0;
        compares = 0;
        repeat (5) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        // Reset state, register read and unmapped access
        chk("lock_err", 1'h1, lerr);
        chk("osc", 1'h1, osc);
        chk("pin_oe", 1'h1, oe);
        chk("pin_out", 1'h1, pin_out);
        chk("stream", 1'h0, ssel);
        bus(1'b0, 8'h00, 32'h0, 1'b0);
        chk("sys", 32'h0, q);
        bus(1'b0, 8'h40, 32'h0, 1'b1);
        chk("unmapped", 32'h0, q);
        // First lock: crystal to PLL after the switch delay
        run <= 1'b1;
        rx <= 1'b1;
        wait_err(1'b0);
        chk("lock_time", 32'd66, n);
        chk("osc", 1'h0, osc);
        chk("src", 1'h1, src);
        chk("mult", spdif_sup_pkg::MULT_512, mult);
        repeat (2) @(posedge CLK);
        chk("data", 1'h1, sdo);
        // Bad preamble drops lock; fixed multiple taken at relock
        bad <= 1'b1;
        @(posedge CLK);
        bad <= 1'b0;
        repeat (2) @(posedge CLK);
        chk("lock_err", 1'h1, lerr);
        chk("data", 1'h0, sdo);
        bus(1'b1, 8'h04, 32'h11, 1'b0);
        bus(1'b1, 8'h00, 32'h10, 1'b0);
        wait_err(1'b0);
        chk("lock_wait", 32'd101, n);
        chk("mult", spdif_sup_pkg::MULT_128, mult);
        repeat (2) @(posedge CLK);
        chk("data", 1'h1, sdo);
        // Variable multiple taken at relock; short carrier loss drops pending switch
        bus(1'b1, 8'h04, 32'h04, 1'b0);
        bus(1'b0, 8'h04, 32'h0, 1'b0);
        chk("clk", 32'h04, q);
        fs <= spdif_sup_pkg::FS_DOUBLE;
        run <= 1'b0;
        repeat (10) @(posedge CLK);
        run <= 1'b1;
        repeat (SW + 20) @(posedge CLK);
        chk("src", 1'h1, src);
        wait_err(1'b0);
        chk("mult", spdif_sup_pkg::MULT_512, mult);
        fs <= spdif_sup_pkg::FS_QUAD;
        repeat (2) @(posedge CLK);
        chk("mult", spdif_sup_pkg::MULT_128, mult);
        // Carrier lost: oscillator back, mute, then aux data
        aux <= 1'b1;
        run <= 1'b0;
        wait_err(1'b1);
        chk("osc", 1'h1, osc);
        repeat (250 * TD) @(posedge CLK);
        chk("data", 1'h0, sdo);
        chk("src", 1'h0, src);
        repeat (12 * TD) @(posedge CLK);
        chk("data", 1'h1, sdo);
        // Reject mode with carrier present, pin made an input
        bus(1'b1, 8'h00, 32'h48, 1'b0);
        bus(1'b0, 8'h00, 32'h0, 1'b0);
        chk("sys", 32'h48, q);
        chk("pin_oe", 1'h0, oe);
        bus(1'b1, 8'h08, 32'h2, 1'b0);
        run <= 1'b1;
        rx <= 1'b0;
        repeat (SW + 100) @(posedge CLK);
        chk("lock_err", 1'h1, lerr);
        chk("src", 1'h0, src);
        chk("mult", spdif_sup_pkg::MULT_XTAL, mult);
        chk("stream", 1'h1, ssel);
        chk("data", 1'h1, sdo);
        aux <= 1'b0;
        repeat (2) @(posedge CLK);
        chk("data", 1'h0, sdo);
        end_of_test;
    end
endmodule
